/* File: dcse_params.svh */
// constants for the dual channel safe input evaluator
`ifndef DCSE_PARAMS_SVH
`define DCSE_PARAMS_SVH
`define DCSE_CLK_MHZ 250
`define DCSE_DISC_TIME_US 20000
`define DCSE_DISC_CYCLES (`DCSE_DISC_TIME_US * `DCSE_CLK_MHZ)
`define DCSE_PULSE_TIME_US 1000
`define DCSE_PULSE_CYCLES (`DCSE_PULSE_TIME_US * `DCSE_CLK_MHZ)
`define DCSE_SETTLE_CYCLES 16
`endif

/* File: dcse_pkg.sv */
// types shared by the dual channel safe input evaluator
`default_nettype none
package dcse_pkg;
  typedef enum logic [1:0] {
    DCSE_NONE,
    DCSE_FIRST_ONLY,
    DCSE_SECOND_ONLY,
    DCSE_BOTH
  } dcse_cond_e;
  typedef struct packed {
    logic disc_first;
    logic disc_second;
    logic cross_fault;
  } dcse_err_s;
  typedef struct packed {
    logic restricted;
    logic position_ok;
  } dcse_gate_s;
endpackage
`default_nettype wire

/* File: dcse_disc_timer.sv */
// discrepancy timer for one dual channel input pair
`timescale 1ns/1ps
`default_nettype none
module dcse_disc_timer #(
  parameter int unsigned LIMIT = 5000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pair levels
  input wire logic ch_a,
  input wire logic ch_b,
  // expiry
  output logic expired
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_q;

  // refuse a limit the counter cannot serve
  if (LIMIT < 1) begin : g_bad_limit
    $error("LIMIT must be at least one");
  end

  // count while channels differ, restart when they agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (ch_a == ch_b) begin
      cnt_q <= '0;
    end else if (cnt_q != W'(LIMIT)) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign expired = (cnt_q == W'(LIMIT));

  a_timer_expiry: assert property (@(posedge clk) disable iff (!arst_n)
    (ch_a == ch_b) |=> !expired) else $error("timer expired on agree");
  a_timer_count: assert property (@(posedge clk) disable iff (!arst_n)
    (ch_a != ch_b && !expired) |=> cnt_q == $past(cnt_q) + W'(1))
    else $error("timer did not advance");
endmodule // dcse_disc_timer
`default_nettype wire

/* File: dcse_eval.sv */
// dual channel safe input evaluation with cross-circuit test pulses
//
// Notes on behaviour
// - inputs one and two form the first pair, three and four the second.
// - pair states decode into both, first only, second only or none.
// - a pair is actuated when either input is low, idle only if both high.
// - second pair channels, and first pair ones without cross test, differing longer than the limit latch the error state.
// - without cross test the request comes from the second pair alone.
// - in cross test the first pair is fed from test outputs A and B.
// - one test output A and one test output B exist per module.
// - shorts between the adjacent inputs one and two and inputs held high under their own pulse are detected; others by wiring.
// - position functions run only once all axes are referenced.
// - digital-link encoders keep the device restricted until verified.
`timescale 1ns/1ps
`default_nettype none
`include "dcse_params.svh"
module dcse_eval #(
  parameter int unsigned DISC_CYCLES = `DCSE_DISC_CYCLES,
  parameter int unsigned PULSE_CYCLES = `DCSE_PULSE_CYCLES,
  parameter int unsigned SETTLE_CYCLES = `DCSE_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // safe inputs, index 0 is input one
  input wire logic [3:0] safe_in,
  // configuration
  input wire logic cross_test_en,
  input wire logic digital_link_enc,
  input wire logic all_axes_referenced,
  input wire logic enc_verified,
  input wire logic err_clear,
  // test signal outputs
  output logic test_sig_a,
  output logic test_sig_b,
  // evaluation results
  output dcse_pkg::dcse_cond_e pair_cond,
  output logic safety_request,
  output logic error_state,
  output dcse_pkg::dcse_err_s err_cause,
  output dcse_pkg::dcse_gate_s gate,
  output logic limited_position_function_en,
  output logic maximum_position_function_en
);
  // ------------------------------------------------------------
  // pair decode
  // ------------------------------------------------------------
  // the settle point must fall inside one pulse phase
  if (SETTLE_CYCLES >= PULSE_CYCLES) begin : g_bad_settle
    $error("SETTLE_CYCLES must be below PULSE_CYCLES");
  end

  // actuated when at least one input of the pair is low
  function automatic logic pair_act(input logic a, input logic b);
    return !(a && b);
  endfunction

  logic first_act;
  logic second_act;
  logic first_exp;
  logic second_exp;
  logic cross_mis;

  assign first_act = pair_act(safe_in[0], safe_in[1]);
  assign second_act = pair_act(safe_in[2], safe_in[3]);

  // ------------------------------------------------------------
  // discrepancy timers, one per pair
  // ------------------------------------------------------------
  // first pair is pulse driven in cross test; pulses are checked instead
  logic first_a_eff;
  assign first_a_eff = cross_test_en ? safe_in[1] : safe_in[0];

  dcse_disc_timer #(.LIMIT(DISC_CYCLES)) u_first_timer (
    .clk(clk),
    .arst_n(arst_n),
    .ch_a(first_a_eff),
    .ch_b(safe_in[1]),
    .expired(first_exp)
  );

  dcse_disc_timer #(.LIMIT(DISC_CYCLES)) u_second_timer (
    .clk(clk),
    .arst_n(arst_n),
    .ch_a(safe_in[2]),
    .ch_b(safe_in[3]),
    .expired(second_exp)
  );

  // ------------------------------------------------------------
  // test pulse generator, A and B pulse low in turn
  // ------------------------------------------------------------
  localparam int PW = $clog2(PULSE_CYCLES + 1);
  logic [PW-1:0] pcnt_q;
  logic [1:0] phase_q;

  // phase timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pcnt_q <= '0;
      phase_q <= 2'h0;
    end else if (pcnt_q == PW'(PULSE_CYCLES - 1)) begin
      pcnt_q <= '0;
      phase_q <= phase_q + 2'h1;
    end else begin
      pcnt_q <= pcnt_q + PW'(1);
    end
  end

  // one A and one B output per module, both high outside cross test
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_sig_a <= 1'b1;
      test_sig_b <= 1'b1;
    end else begin
      test_sig_a <= !(cross_test_en && phase_q == 2'h1);
      test_sig_b <= !(cross_test_en && phase_q == 2'h3);
    end
  end

  // ------------------------------------------------------------
  // cross-circuit check on the first pair
  // ------------------------------------------------------------
  // sampled after settling; a short to the neighbour copies the pulse
  logic settled;
  assign settled = (pcnt_q == PW'(SETTLE_CYCLES));
  // input one follows A, input two follows B; an input high under its own
  // low pulse, input two copying A, or both low under one pulse is a fault
  // (shorts between the adjacent inputs one and two, or of either to the supply, can show here)
  assign cross_mis = cross_test_en && settled && (
    (!test_sig_a && safe_in[0]) ||
    (!test_sig_b && safe_in[1]) ||
    (!test_sig_a && test_sig_b && !safe_in[1]) ||
    (test_sig_a != test_sig_b && !safe_in[0] && !safe_in[1]));

  // ------------------------------------------------------------
  // error latch
  // ------------------------------------------------------------
  // events set the latch; set wins over a simultaneous clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_cause <= '0;
    end else begin
      err_cause.disc_first <= first_exp ||
        (err_cause.disc_first && !err_clear);
      err_cause.disc_second <= second_exp ||
        (err_cause.disc_second && !err_clear);
      err_cause.cross_fault <= cross_mis ||
        (err_cause.cross_fault && !err_clear);
    end
  end

  assign error_state = |err_cause;

  // ------------------------------------------------------------
  // condition decode and request
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pair_cond <= dcse_pkg::DCSE_BOTH;
      safety_request <= 1'b1;
    end else begin
      if (first_act && second_act) begin
        pair_cond <= dcse_pkg::DCSE_BOTH;
      end else if (first_act) begin
        pair_cond <= dcse_pkg::DCSE_FIRST_ONLY;
      end else if (second_act) begin
        pair_cond <= dcse_pkg::DCSE_SECOND_ONLY;
      end else begin
        pair_cond <= dcse_pkg::DCSE_NONE;
      end
      // without cross test only the second pair requests
      safety_request <= cross_test_en ? (first_act || second_act) :
        second_act;
    end
  end

  // ------------------------------------------------------------
  // referencing and verification gates
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate <= '{restricted: 1'b1, position_ok: 1'b0};
    end else begin
      gate.restricted <= digital_link_enc && !enc_verified;
      gate.position_ok <= all_axes_referenced;
    end
  end

  assign limited_position_function_en = gate.position_ok;
  assign maximum_position_function_en = gate.position_ok;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_err_set;
    first_exp || second_exp || cross_mis;
  endsequence

  a_error_latch: assert property (@(posedge clk) disable iff (!arst_n)
    s_err_set |=> error_state [*2]) else $error("error not latched");
  a_act_decode: assert property (@(posedge clk) disable iff (!arst_n)
    (safe_in == 4'hF) |=> pair_cond == dcse_pkg::DCSE_NONE)
    else $error("idle pairs decoded as actuated");
  a_both_decode: assert property (@(posedge clk) disable iff (!arst_n)
    (!safe_in[0] && !safe_in[3]) |=> pair_cond == dcse_pkg::DCSE_BOTH)
    else $error("both pairs not decoded");
  a_second_req: assert property (@(posedge clk) disable iff (!arst_n)
    (!cross_test_en && safe_in[3:2] == 2'h3) |=> !safety_request)
    else $error("request without second pair");
  a_pos_gate: assert property (@(posedge clk) disable iff (!arst_n)
    limited_position_function_en |-> $past(all_axes_referenced))
    else $error("position function before referencing");
  a_enc_restrict: assert property (@(posedge clk) disable iff (!arst_n)
    (digital_link_enc && !enc_verified) |=> gate.restricted)
    else $error("unverified encoder not restricted");
  a_pulse_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !(cross_test_en) |=> test_sig_a && test_sig_b)
    else $error("test pulse outside cross test");
  a_pulse_apart: assert property (@(posedge clk) disable iff (!arst_n)
    !(!test_sig_a && !test_sig_b)) else $error("pulses overlap");
  a_cross_latch: assert property (@(posedge clk) disable iff (!arst_n)
    cross_mis |=> err_cause.cross_fault)
    else $error("cross fault not latched");
endmodule // dcse_eval
`default_nettype wire

/* File: dcse_switch_model.sv */
// model of the external safety contacts wired to the safe inputs
`timescale 1ns/1ps
`default_nettype none
module dcse_switch_model (
  // contact state and fault injection
  input wire logic [3:0] open_ch,
  input wire logic short12,
  input wire logic short_sup,
  input wire logic cross_test_en,
  // test pulses from the device
  input wire logic test_sig_a,
  input wire logic test_sig_b,
  // levels at the safe inputs, an open contact reads low
  output logic [3:0] safe_in
);
  logic in1;
  logic in2;
  logic [1:0] pair1;
  // first pair is fed from A and B in the cross test variant
  assign in1 = ~open_ch[0] & (cross_test_en ? test_sig_a : 1'b1);
  assign in2 = ~open_ch[1] & (cross_test_en ? test_sig_b : 1'b1);
  // a short between the adjacent inputs one and two is injected here, low wins
  assign pair1 = short12 ? {2{in1 & in2}} : {in2, in1};
  // a short of input one to the supply holds it high
  assign safe_in[0] = pair1[0] | short_sup;
  assign safe_in[1] = pair1[1];
  // second pair is fed straight from the supply
  assign safe_in[3:2] = ~open_ch[3:2];
endmodule // dcse_switch_model
`default_nettype wire

/* File: dcse_eval_bench.sv */
// self-checking bench for the dual channel safe input evaluator
`timescale 1ns/1ps
`default_nettype none
module dcse_eval_bench;
  localparam int unsigned DISC = 8;
  localparam int unsigned PULSE = 32;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] safe_in;
  logic [3:0] open_ch = 4'h0;
  logic short12 = 1'b0;
  logic short_sup = 1'b0;
  logic cross_en = 1'b0;
  logic dl_enc = 1'b0;
  logic axes_ref = 1'b0;
  logic enc_ver = 1'b0;
  logic err_clear = 1'b0;
  logic sig_a;
  logic sig_b;
  dcse_pkg::dcse_cond_e cond;
  logic req;
  logic err;
  dcse_pkg::dcse_err_s cause;
  dcse_pkg::dcse_gate_s gate;
  logic lim_en;
  logic max_en;
  int n_errors = 0;
  int n_tests = 0;
  // 4 ns clock
  always #2 clk = ~clk;
  dcse_switch_model u_dcse_switch_model (.open_ch(open_ch),
    .short12(short12), .short_sup(short_sup), .cross_test_en(cross_en),
    .test_sig_a(sig_a), .test_sig_b(sig_b), .safe_in(safe_in));
  dcse_eval #(.DISC_CYCLES(DISC), .PULSE_CYCLES(PULSE),
    .SETTLE_CYCLES(4)) u_dcse_eval (.clk(clk), .arst_n(arst_n),
    .safe_in(safe_in), .cross_test_en(cross_en), .digital_link_enc(dl_enc),
    .all_axes_referenced(axes_ref), .enc_verified(enc_ver),
    .err_clear(err_clear), .test_sig_a(sig_a), .test_sig_b(sig_b),
    .pair_cond(cond), .safety_request(req), .error_state(err),
    .err_cause(cause), .gate(gate), .limited_position_function_en(lim_en),
    .maximum_position_function_en(max_en));
  // advance n edges and land 1 ns after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string s);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s is %b", $time, s, got);
    end
  endtask
  task automatic check_cond(input dcse_pkg::dcse_cond_e got,
                            input dcse_pkg::dcse_cond_e exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: condition %0d not %0d", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // bounded wait for the error state, a timeout ends the run
  task automatic wait_error(input int lim);
    for (int i = 0; i < lim && err !== 1'b1; i++) tick(1);
    if (err !== 1'b1) begin
      n_errors++;
      $display("MISMATCH at %0t: no error state in time", $time);
      end_of_test();
    end
  endtask
  // drop the failing cause, then clear the latched error
  task automatic clear_err();
    open_ch = 4'h0;
    short12 = 1'b0;
    short_sup = 1'b0;
    tick(2);
    err_clear = 1'b1;
    tick(1);
    err_clear = 1'b0;
    tick(1);
    check_bit(err, 1'b0, "error after clear");
  endtask
  // every contact pattern against the pair decode
  task automatic test_decode();
    logic p1;
    logic p2;
    for (int i = 0; i < 16; i++) begin
      open_ch = 4'(i);
      p1 = open_ch[0] | open_ch[1];
      p2 = open_ch[2] | open_ch[3];
      tick(2);
      check_cond(cond, dcse_pkg::dcse_cond_e'({p2, p1}));
      check_bit(req, p2, "request");
      open_ch = 4'h0;
      tick(2);
    end
    check_bit(err, 1'b0, "error on short skew");
    $display("test decode done");
  endtask
  // discrepancy limit, restart on agreement, latch and clear
  task automatic test_disc();
    open_ch = 4'h4;
    tick(DISC - 2);
    check_bit(err, 1'b0, "early error");
    open_ch = 4'h0;
    tick(1);
    open_ch = 4'h4;
    tick(DISC - 2);
    check_bit(err, 1'b0, "no restart");
    wait_error(5);
    check_bit(cause.disc_second, 1'b1, "second cause");
    check_bit(cause.disc_first, 1'b0, "first cause");
    // a clear while the discrepancy persists must not win
    err_clear = 1'b1;
    tick(2);
    err_clear = 1'b0;
    check_bit(cause.disc_second, 1'b1, "set over clear");
    clear_err();
    open_ch = 4'h2;
    wait_error(DISC + 4);
    check_bit(cause.disc_first, 1'b1, "first cause");
    clear_err();
    $display("test discrepancy done");
  endtask
  // test pulses with clean wiring, then an adjacent short
  task automatic test_cross();
    logic a_low = 1'b0;
    logic b_low = 1'b0;
    cross_en = 1'b1;
    for (int i = 0; i < 8 * PULSE; i++) begin
      tick(1);
      a_low |= (sig_a === 1'b0);
      b_low |= (sig_b === 1'b0);
    end
    check_bit(a_low & b_low, 1'b1, "pulses");
    check_bit(err, 1'b0, "false cross fault");
    short12 = 1'b1;
    wait_error(8 * PULSE);
    check_bit(cause.cross_fault, 1'b1, "cross cause");
    clear_err();
    // input one shorted to the supply no longer follows pulse A
    short_sup = 1'b1;
    wait_error(8 * PULSE);
    check_bit(cause.cross_fault, 1'b1, "stuck high cause");
    clear_err();
    cross_en = 1'b0;
    tick(2);
    $display("test cross done");
  endtask
  // referencing and encoder verification gates
  task automatic test_gate();
    check_bit(gate.restricted, 1'b0, "no digital link");
    dl_enc = 1'b1;
    tick(2);
    check_bit(gate.restricted, 1'b1, "restricted");
    check_bit(lim_en | max_en, 1'b0, "position unreferenced");
    enc_ver = 1'b1;
    axes_ref = 1'b1;
    tick(2);
    check_bit(gate.restricted, 1'b0, "verified");
    check_bit(lim_en & max_en, 1'b1, "position referenced");
    $display("test gate done");
  endtask
  // reset for 5 cycles, then the scenarios
  initial begin
    tick(5);
    arst_n = 1'b1;
    tick(2);
    test_decode();
    test_disc();
    test_cross();
    test_gate();
    end_of_test();
  end
endmodule // dcse_eval_bench
`default_nettype wire
